/* verilog/ims_pkg.sv */
// shared constants, register map and carrier types of the input mode detect and scaler block
// assumes one AHB-Lite slave port, word accesses only, and sampled video and clock pins
package ims_pkg;

    localparam int MODE_NUM = 14;
    localparam int RES_W = 11;
    localparam int TOT_W = 12;
    localparam int SCALE_FRAC = 12;
    localparam int SCALE_W = 16;
    localparam int DIV_W = 24;
    localparam logic [4:0] DIV_STEPS = 5'h18;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MANUAL_MODE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_HMEAS = 8'h0c;
    localparam logic [7:0] OFS_HACT = 8'h10;
    localparam logic [7:0] OFS_VMEAS = 8'h14;
    localparam logic [7:0] OFS_VACT = 8'h18;
    localparam logic [7:0] OFS_PANEL_SIZE = 8'h1c;
    localparam logic [7:0] OFS_PANEL_SYNC = 8'h20;
    localparam logic [7:0] OFS_SCALE = 8'h24;
    localparam logic [7:0] OFS_MODE_RES = 8'h40;
    localparam logic [7:0] OFS_MODE_TOT = 8'h80;

    // control bit positions
    localparam int CTRL_AUTO = 0;
    localparam int CTRL_HS_HIGH = 1;
    localparam int CTRL_VS_HIGH = 2;
    localparam int CTRL_DE_LOW = 3;
    localparam logic [3:0] CTRL_RESET = 4'h1;

    // panel reset values
    localparam logic [10:0] PANEL_HSIZE_RESET = 11'h400;
    localparam logic [10:0] PANEL_VSIZE_RESET = 11'h300;
    localparam logic [7:0] PANEL_HPW_RESET = 8'h20;
    localparam logic [7:0] PANEL_HBP_RESET = 8'h50;
    localparam logic [7:0] PANEL_VPW_RESET = 8'h04;
    localparam logic [7:0] PANEL_VBP_RESET = 8'h14;
    localparam logic [11:0] MODE_HTOT_RESET = 12'h540;
    localparam logic [11:0] MODE_VTOT_RESET = 12'h326;

    // default resolution table {vres, hres}; remaining entries cleared
    localparam int DEF_MODES = 7;
    localparam logic [21:0] DEF_MODE_RES [0:DEF_MODES-1] = '{
        {11'h15e, 11'h280}, {11'h190, 11'h280}, {11'h190, 11'h2d0}, {11'h1e0, 11'h280},
        {11'h258, 11'h320}, {11'h270, 11'h340}, {11'h300, 11'h400}};

    typedef struct packed {
        logic [10:0] pw;
        logic [10:0] bp;
        logic [10:0] act;
    } ims_meas_type;

    typedef struct packed {
        logic [10:0] hsize;
        logic [10:0] vsize;
        logic [7:0] hpw;
        logic [7:0] hbp;
        logic [7:0] vpw;
        logic [7:0] vbp;
    } ims_panel_type;

    typedef enum logic [1:0] {DV_IDLE, DV_WAIT_REF, DV_H, DV_V} ims_div_state_type;

endpackage

/* verilog/ims_top.sv */
// input mode detection, scaling ratio and line buffer control with panel timing generation
// assumes pixel, panel and reference clocks arrive as pins sampled by hclk, far slower than it
// How it works
// - up to fourteen modes, keyed by resolution
// - frame rate ignored, same resolution same mode
// - seven default resolutions preloaded in table
// - output frame restarted by each input frame
// - sync polarity found from level lengths
// - pulse, back porch, active measured both directions
// - measurements drive mode, pll lock, scaling
// - detection runs every frame without command
// - control bit enables automatic detection
// - manual mode register used when detection off
// - reference clock paces configuration table access
// - write/read control address line buffer regions
// - ratios computed from panel and source sizes
// - ratios recomputed on every mode change
// - read side may repeat pixels and lines
// - display enable polarity programmable, default high
// - default horizontal sync output active low
// - system reset is active low
// - feedback clock out, synthesiser clock in
// - output syncs programmable polarity, default low
// - panel totals loaded per active mode
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
module ims_top import ims_pkg::*; #(
    parameter int LB_ADDR_W = 12,
    parameter int PIX_W = 24
) (
    input wire logic hclk, // system clock
    input wire logic hresetn, // asynchronous reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write not read
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic vid_clk, // input pixel clock pin
    input wire logic vid_hsync, // input horizontal sync, either polarity
    input wire logic vid_vsync, // input vertical sync, either polarity
    input wire logic vid_de, // input data enable, active high
    input wire logic [PIX_W-1:0] vid_data, // input pixel
    input wire logic free_run_ref_clock, // free running reference clock pin
    output logic free_run_clock_feedback, // reference clock feedback
    output logic synth_feedback_clock, // feedback to output synthesiser
    input wire logic synth_pixel_clock, // synthesiser output, panel pixel clock
    output logic panel_hsync, // panel horizontal sync
    output logic panel_vsync, // panel vertical sync
    output logic panel_display_enable, // panel data enable
    output logic [PIX_W-1:0] panel_data, // panel pixel
    output logic hsync_default_n // default horizontal sync, active low
);
    localparam int IN_W = PIX_W + 6;

    logic [IN_W-1:0] in_s1, in_s2, in_s3, in_f;
    logic vclk_d, pclk_d, ref_d;
    logic [PIX_W-1:0] pin_data;
    logic pin_hs, pin_vs, pin_de, pin_vclk, pin_pclk, pin_ref;
    logic vtick, ptick, rtick;

    // three stage sampling, a change is taken once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_s1 <= '0;
            in_s2 <= '0;
            in_s3 <= '0;
            in_f <= '0;
        end else begin
            in_s1 <= {free_run_ref_clock, synth_pixel_clock, vid_clk, vid_de, vid_vsync, vid_hsync, vid_data};
            in_s2 <= in_s1;
            in_s3 <= in_s2;
            in_f <= (in_s3 & ~(in_s2 ^ in_s3)) | (in_f & (in_s2 ^ in_s3));
        end
    end
    assign {pin_ref, pin_pclk, pin_vclk, pin_de, pin_vs, pin_hs, pin_data} = in_f;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vclk_d <= 1'b0;
            pclk_d <= 1'b0;
            ref_d <= 1'b0;
        end else begin
            vclk_d <= pin_vclk;
            pclk_d <= pin_pclk;
            ref_d <= pin_ref;
        end
    end
    assign vtick = pin_vclk & ~vclk_d;
    assign ptick = pin_pclk & ~pclk_d;
    assign rtick = pin_ref & ~ref_d;

    // ---------------- input measurement ----------------
    logic hs_d, vs_d, de_d, pol_h, pol_v, hs_act, vs_act, hs_act_d, vs_act_d;
    logic [10:0] h_lvl_cnt, h_hi_len, h_lo_len, v_lvl_cnt, v_hi_len, v_lo_len;
    logic [10:0] hpos, de_cnt, vline, vact_cnt;
    logic frame_de_seen, in_line, frame_done, in_vs_start;
    logic hs_start, vs_start;
    ims_meas_type hmeas, vmeas;

    assign hs_act = pol_h ? pin_hs : ~pin_hs;
    assign vs_act = pol_v ? pin_vs : ~pin_vs;
    assign hs_start = vtick & hs_act & ~hs_act_d;
    assign vs_start = hs_start & vs_act & ~vs_act_d;
    assign pol_h = h_hi_len < h_lo_len;
    assign pol_v = v_hi_len < v_lo_len;

    // sync level lengths, shorter level is the pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hs_d <= 1'b0;
            vs_d <= 1'b0;
            h_lvl_cnt <= '0;
            h_hi_len <= '1;
            h_lo_len <= '1;
            v_lvl_cnt <= '0;
            v_hi_len <= '1;
            v_lo_len <= '1;
        end else if (vtick) begin
            hs_d <= pin_hs;
            h_lvl_cnt <= (pin_hs != hs_d) ? 11'h001 : h_lvl_cnt + 11'h001;
            if (pin_hs != hs_d && hs_d) h_hi_len <= h_lvl_cnt;
            if (pin_hs != hs_d && !hs_d) h_lo_len <= h_lvl_cnt;
            if (hs_start) begin
                vs_d <= pin_vs;
                v_lvl_cnt <= (pin_vs != vs_d) ? 11'h001 : v_lvl_cnt + 11'h001;
                if (pin_vs != vs_d && vs_d) v_hi_len <= v_lvl_cnt;
                if (pin_vs != vs_d && !vs_d) v_lo_len <= v_lvl_cnt;
            end
        end
    end

    // porch, pulse and window sizes in pixels and lines
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hs_act_d <= 1'b0;
            vs_act_d <= 1'b0;
            de_d <= 1'b0;
            hpos <= '0;
            de_cnt <= '0;
            vline <= '0;
            vact_cnt <= '0;
            frame_de_seen <= 1'b0;
            in_line <= 1'b0;
            hmeas <= '0;
            vmeas <= '0;
        end else if (vtick) begin
            hs_act_d <= hs_act;
            de_d <= pin_de;
            hpos <= hs_start ? 11'h000 : hpos + 11'h001;
            if (!hs_act && hs_act_d) hmeas.pw <= hpos + 11'h001;
            if (pin_de && !de_d) begin
                hmeas.bp <= hpos + 11'h001;
                in_line <= 1'b1;
                if (!frame_de_seen) vmeas.bp <= vline;
                frame_de_seen <= 1'b1;
            end
            de_cnt <= pin_de ? de_cnt + 11'h001 : 11'h000;
            if (!pin_de && de_d) hmeas.act <= de_cnt;
            if (hs_start) begin
                vs_act_d <= vs_act;
                in_line <= 1'b0;
                vline <= vs_start ? 11'h000 : vline + 11'h001;
                if (in_line) vact_cnt <= vact_cnt + 11'h001;
                if (!vs_act && vs_act_d) vmeas.pw <= vline + 11'h001;
                if (vs_start) begin
                    vmeas.act <= vact_cnt + {10'h000, in_line};
                    vact_cnt <= '0;
                    frame_de_seen <= 1'b0;
                end
            end
        end
    end
    assign frame_done = vs_start;
    assign in_vs_start = vs_start;

    // ---------------- registers ----------------
    logic [3:0] ctrl, manual_mode, det_mode, act_mode, loaded_mode;
    logic det_valid, loaded_ok, act_valid;
    logic [21:0] mode_res [0:MODE_NUM-1];
    logic [23:0] mode_tot [0:MODE_NUM-1];
    ims_panel_type panel;
    logic [SCALE_W-1:0] ratio_h, ratio_v;
    logic [11:0] cur_htot, cur_vtot;
    logic ap_valid, wr_pend, rd_pend;
    logic [7:0] wr_addr, rd_addr;

    // mode match against the table at each frame end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            det_mode <= '0;
            det_valid <= 1'b0;
        end else if (frame_done) begin
            det_valid <= 1'b0;
            for (int i = MODE_NUM - 1; i >= 0; i--) begin
                if (mode_res[i][10:0] != 11'h000 && mode_res[i] == {vmeas.act, hmeas.act}) begin
                    det_mode <= 4'(i);
                    det_valid <= 1'b1;
                end
            end
        end
    end
    assign act_mode = ctrl[CTRL_AUTO] ? det_mode : manual_mode;
    assign act_valid = ctrl[CTRL_AUTO] ? det_valid : (manual_mode < 4'(MODE_NUM));

    // ahb-lite: writes finish with no wait, reads insert one wait for registered data
    assign ap_valid = hsel & hready & htrans[1];
    assign hreadyout = ~rd_pend;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= '0;
            rd_addr <= '0;
        end else begin
            wr_pend <= ap_valid & hwrite & (hsize == 3'b010);
            rd_pend <= ap_valid & ~hwrite;
            if (ap_valid) begin
                wr_addr <= haddr[7:0];
                rd_addr <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= CTRL_RESET;
            manual_mode <= '0;
            panel <= {PANEL_HSIZE_RESET, PANEL_VSIZE_RESET, PANEL_HPW_RESET, PANEL_HBP_RESET,
                      PANEL_VPW_RESET, PANEL_VBP_RESET};
            for (int i = 0; i < MODE_NUM; i++) begin
                mode_res[i] <= (i < DEF_MODES) ? DEF_MODE_RES[i % DEF_MODES] : 22'h000000;
                mode_tot[i] <= {MODE_VTOT_RESET, MODE_HTOT_RESET};
            end
        end else if (wr_pend) begin
            if (wr_addr == OFS_CTRL) begin
                ctrl <= hwdata[3:0];
            end else if (wr_addr == OFS_MANUAL_MODE) begin
                manual_mode <= hwdata[3:0];
            end else if (wr_addr == OFS_PANEL_SIZE) begin
                panel.hsize <= hwdata[10:0];
                panel.vsize <= hwdata[26:16];
            end else if (wr_addr == OFS_PANEL_SYNC) begin
                {panel.vbp, panel.vpw, panel.hbp, panel.hpw} <= hwdata;
            end else if (wr_addr >= OFS_MODE_RES && wr_addr < OFS_MODE_RES + 8'(4 * MODE_NUM)) begin
                mode_res[4'((wr_addr - OFS_MODE_RES) >> 2)] <= {hwdata[26:16], hwdata[10:0]};
            end else if (wr_addr >= OFS_MODE_TOT && wr_addr < OFS_MODE_TOT + 8'(4 * MODE_NUM)) begin
                mode_tot[4'((wr_addr - OFS_MODE_TOT) >> 2)] <= {hwdata[27:16], hwdata[11:0]};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (rd_pend) begin
            hrdata <= '0;
            if (rd_addr == OFS_CTRL) begin
                hrdata <= {28'h0000000, ctrl};
            end else if (rd_addr == OFS_MANUAL_MODE) begin
                hrdata <= {28'h0000000, manual_mode};
            end else if (rd_addr == OFS_STATUS) begin
                hrdata <= {20'h00000, loaded_ok, pol_v, pol_h, det_valid, det_mode, act_mode};
            end else if (rd_addr == OFS_HMEAS) begin
                hrdata <= {5'h00, hmeas.bp, 5'h00, hmeas.pw};
            end else if (rd_addr == OFS_HACT) begin
                hrdata <= {21'h000000, hmeas.act};
            end else if (rd_addr == OFS_VMEAS) begin
                hrdata <= {5'h00, vmeas.bp, 5'h00, vmeas.pw};
            end else if (rd_addr == OFS_VACT) begin
                hrdata <= {21'h000000, vmeas.act};
            end else if (rd_addr == OFS_PANEL_SIZE) begin
                hrdata <= {5'h00, panel.vsize, 5'h00, panel.hsize};
            end else if (rd_addr == OFS_PANEL_SYNC) begin
                hrdata <= {panel.vbp, panel.vpw, panel.hbp, panel.hpw};
            end else if (rd_addr == OFS_SCALE) begin
                hrdata <= {ratio_v, ratio_h};
            end else if (rd_addr >= OFS_MODE_RES && rd_addr < OFS_MODE_RES + 8'(4 * MODE_NUM)) begin
                hrdata <= {5'h00, mode_res[4'((rd_addr - OFS_MODE_RES) >> 2)][21:11], 5'h00,
                           mode_res[4'((rd_addr - OFS_MODE_RES) >> 2)][10:0]};
            end else if (rd_addr >= OFS_MODE_TOT && rd_addr < OFS_MODE_TOT + 8'(4 * MODE_NUM)) begin
                hrdata <= {4'h0, mode_tot[4'((rd_addr - OFS_MODE_TOT) >> 2)][23:12], 4'h0,
                           mode_tot[4'((rd_addr - OFS_MODE_TOT) >> 2)][11:0]};
            end
        end
    end

    // ---------------- mode load and ratio divider ----------------
    ims_div_state_type dv_state;
    logic [DIV_W-1:0] dv_rem, dv_num, dv_shift;
    logic [10:0] dv_den;
    logic [4:0] dv_cnt;

    assign dv_shift = {dv_rem[DIV_W-2:0], dv_num[DIV_W-1]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dv_state <= DV_IDLE;
            dv_rem <= '0;
            dv_num <= '0;
            dv_den <= '0;
            dv_cnt <= '0;
            loaded_mode <= '0;
            loaded_ok <= 1'b0;
            cur_htot <= MODE_HTOT_RESET;
            cur_vtot <= MODE_VTOT_RESET;
            ratio_h <= '0;
            ratio_v <= '0;
        end else begin
            case (dv_state)
                DV_IDLE: begin
                    if (act_valid && (act_mode != loaded_mode || !loaded_ok)) dv_state <= DV_WAIT_REF;
                end
                DV_WAIT_REF: begin
                    if (!act_valid) begin
                        dv_state <= DV_IDLE;
                    end else if (rtick) begin
                        {cur_vtot, cur_htot} <= mode_tot[act_mode];
                        loaded_mode <= act_mode;
                        loaded_ok <= 1'b1;
                        dv_num <= {2'b00, mode_res[act_mode][10:0], 11'h000} << 1;
                        dv_rem <= '0;
                        dv_den <= panel.hsize;
                        dv_cnt <= DIV_STEPS;
                        dv_state <= DV_H;
                    end
                end
                DV_H, DV_V: begin
                    if (dv_cnt != 5'h00) begin
                        dv_cnt <= dv_cnt - 5'h01;
                        if (dv_shift >= {13'h0000, dv_den}) begin
                            dv_rem <= dv_shift - {13'h0000, dv_den};
                            dv_num <= {dv_num[DIV_W-2:0], 1'b1};
                        end else begin
                            dv_rem <= dv_shift;
                            dv_num <= {dv_num[DIV_W-2:0], 1'b0};
                        end
                    end else if (dv_state == DV_H) begin
                        ratio_h <= (dv_num[DIV_W-1:SCALE_W] != '0) ? '1 : dv_num[SCALE_W-1:0];
                        dv_num <= {2'b00, mode_res[loaded_mode][21:11], 11'h000} << 1;
                        dv_rem <= '0;
                        dv_den <= panel.vsize;
                        dv_cnt <= DIV_STEPS;
                        dv_state <= DV_V;
                    end else begin
                        ratio_v <= (dv_num[DIV_W-1:SCALE_W] != '0) ? '1 : dv_num[SCALE_W-1:0];
                        dv_state <= DV_IDLE;
                    end
                end
                default: dv_state <= DV_IDLE;
            endcase
        end
    end

    // ---------------- line buffer ----------------
    logic [PIX_W-1:0] lbuf [0:(1 << LB_ADDR_W)-1];
    logic [LB_ADDR_W-1:0] lb_waddr, lb_raddr;
    logic wr_line;
    logic [DIV_W-1:0] acc_x, acc_y;

    // input lines alternate between two halves of the buffer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_line <= 1'b0;
        end else if (hs_start && in_line) begin
            wr_line <= ~wr_line;
        end
    end
    assign lb_waddr = {wr_line, de_cnt[LB_ADDR_W-2:0]};

    always_ff @(posedge hclk) begin
        if (vtick && pin_de) lbuf[lb_waddr] <= pin_data;
    end

    // ---------------- panel timing ----------------
    logic [11:0] ox, oy;
    logic lock_pend, o_hs, o_vs, o_de, o_line_end;

    assign o_line_end = (ox == cur_htot - 12'h001);
    assign o_hs = ox < {4'h0, panel.hpw};
    assign o_vs = oy < {4'h0, panel.vpw};
    assign o_de = ox >= {4'h0, panel.hbp} && ox < {4'h0, panel.hbp} + {1'b0, panel.hsize}
                  && oy >= {4'h0, panel.vbp} && oy < {4'h0, panel.vbp} + {1'b0, panel.vsize};
    // the read half is the unwritten one, flipped by bit SCALE_FRAC of acc_y; a line is re-read until the source line advances
    assign lb_raddr = {~wr_line ^ acc_y[SCALE_FRAC], acc_x[SCALE_FRAC+LB_ADDR_W-2:SCALE_FRAC]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ox <= '0;
            oy <= '0;
            lock_pend <= 1'b0;
        end else begin
            if (in_vs_start) lock_pend <= 1'b1;
            if (ptick) begin
                ox <= o_line_end ? 12'h000 : ox + 12'h001;
                if (o_line_end) begin
                    if (lock_pend) begin
                        oy <= '0;
                        lock_pend <= in_vs_start;
                    end else begin
                        oy <= (oy == cur_vtot - 12'h001) ? 12'h000 : oy + 12'h001;
                    end
                end
            end
        end
    end

    // fixed point source position; a step below one repeats a pixel or a line
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_x <= '0;
            acc_y <= '0;
        end else if (ptick) begin
            if (o_line_end) begin
                acc_x <= '0;
                if (oy == 12'h000) acc_y <= '0;
                else if (oy >= {4'h0, panel.vbp}) acc_y <= acc_y + {8'h00, ratio_v};
            end else if (o_de) begin
                acc_x <= acc_x + {8'h00, ratio_h};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            panel_hsync <= 1'b1;
            panel_vsync <= 1'b1;
            panel_display_enable <= 1'b0;
            panel_data <= '0;
            hsync_default_n <= 1'b1;
            synth_feedback_clock <= 1'b0;
            free_run_clock_feedback <= 1'b1;
        end else begin
            free_run_clock_feedback <= ~pin_ref;
            if (ptick) begin
                panel_hsync <= o_hs ~^ ctrl[CTRL_HS_HIGH];
                panel_vsync <= o_vs ~^ ctrl[CTRL_VS_HIGH];
                panel_display_enable <= o_de ^ ctrl[CTRL_DE_LOW];
                panel_data <= o_de ? lbuf[lb_raddr] : '0;
                hsync_default_n <= ~o_hs;
                if (o_line_end) synth_feedback_clock <= ~synth_feedback_clock;
            end
        end
    end

endmodule

/* testbench/ims_video_src.sv */
// video source model: 16x8 frame, syncs of either polarity
// assumes a 160 ns pixel clock from the bench
module ims_video_src (
    input wire logic vid_clk, // clock
    input wire logic pol, // syncs high
    output logic vid_hsync, // hsync
    output logic vid_vsync, // vsync
    output logic vid_de, // enable
    output logic [23:0] vid_data // pixel
);
    timeunit 1ns;
    timeprecision 1ns;
    int x = 0;
    int y = 0;
    always @(posedge vid_clk) begin
        x <= (x == 22) ? 0 : x + 1;
        if (x == 22) y <= (y == 13) ? 0 : y + 1;
    end
    // pulse 2, data from pixel 5 and line 4
    assign vid_hsync = pol ^ (x > 1);
    assign vid_vsync = pol ^ (y > 1);
    assign vid_de = x > 4 && x < 21 && y > 3 && y < 12;
    assign vid_data = vid_de ? 24'(x) : ~24'(x);
endmodule

/* testbench/ims_top_assertions.sv */
// checks of bus timing and panel outputs
// assumes it is bound into ims_top
module ims_top_assertions (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset
    input wire logic hsel, // select
    input wire logic [1:0] htrans, // kind
    input wire logic hwrite, // write
    input wire logic hready, // ready
    input wire logic hreadyout, // ready out
    input wire logic hresp, // resp
    input wire logic [31:0] hrdata, // data
    input wire logic free_run_ref_clock, // ref
    input wire logic free_run_clock_feedback, // ref out
    input wire logic synth_feedback_clock, // fb
    input wire logic [23:0] panel_data, // pixel
    input wire logic hsync_default_n // sync
);
    timeunit 1ns;
    timeprecision 1ns;
    wire take = hsel && hready && htrans[1];
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay: assert property (hresp == 1'h0) else $error("resp");
    a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout) else $error("rd");
    a_write_nowait: assert property (take && hwrite |=> hreadyout) else $error("wr");
    a_one_wait: assert property (!hreadyout |=> hreadyout) else $error("wait");
    a_rdata_moment: assert property ($changed(hrdata) |-> !hreadyout || !$past(hreadyout)) else $error("rdata");
    a_ref_follow: assert property ($rose(free_run_ref_clock) |-> ##[1:6] !free_run_clock_feedback) else $error("ref");
    a_blank_sync: assert property (!hsync_default_n |-> panel_data == 24'h0) else $error("blank");
    a_fb_slow: assert property ($changed(synth_feedback_clock) |=> $stable(synth_feedback_clock) [*8]) else $error("fb");
endmodule
bind ims_top ims_top_assertions i_ims_top_assertions (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .free_run_ref_clock, .free_run_clock_feedback, .synth_feedback_clock,
    .panel_data, .hsync_default_n);

/* testbench/test_ims_top.sv */
// bench of ims_top: registers, detection, manual mode, scaling
// assumes the video model and the bound checker
module test_ims_top import ims_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, pol = '0, vclk = '0, rclk = '0, pclk = '0;
    logic [1:0] htrans = '0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic hready, hresp, vhs, vvs, vde, fb, sfb, phs, pvs, pde, hsn;
    logic [23:0] vdata, pdata;
    int n_fail = 0, total_checks = 0, cyc = 0;
    always #10 hclk = ~hclk;
    always #80 vclk = ~vclk;
    always #500 rclk = ~rclk;
    always #60 pclk = ~pclk;
    ims_top i_ims_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
        .hreadyout(hready), .hresp, .hrdata, .vid_clk(vclk), .vid_hsync(vhs), .vid_vsync(vvs), .vid_de(vde),
        .vid_data(vdata), .free_run_ref_clock(rclk), .free_run_clock_feedback(fb), .synth_feedback_clock(sfb),
        .synth_pixel_clock(pclk), .panel_hsync(phs), .panel_vsync(pvs), .panel_display_enable(pde),
        .panel_data(pdata), .hsync_default_n(hsn));
    ims_video_src i_ims_video_src (.vid_clk(vclk), .pol, .vid_hsync(vhs), .vid_vsync(vvs), .vid_de(vde),
        .vid_data(vdata));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'h1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(rd, e);
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        chk({28'h0, phs, pvs, pde, hsn}, 32'hd);
        rchk(OFS_CTRL, 32'h1);
        rchk(OFS_PANEL_SYNC, 32'h14045020);
        rchk(OFS_MODE_RES, 32'h015e0280);
        rchk(8'h58, 32'h03000400);
        rchk(8'h3c, 32'h0);
        $display("reset test done");
        bus(1'h1, OFS_PANEL_SIZE, 32'h00100020);
        bus(1'h1, 8'h5c, 32'h00080010);
        repeat (11000) @(posedge hclk);
        rchk(OFS_STATUS, 32'h977);
        rchk(OFS_HMEAS, 32'h50002);
        rchk(OFS_HACT, 32'h10);
        rchk(OFS_VMEAS, 32'h40002);
        rchk(OFS_VACT, 32'h8);
        rchk(OFS_SCALE, 32'h08000800);
        chk({31'h0, pde}, 32'h0);
        $display("detect test done");
        bus(1'h1, OFS_MANUAL_MODE, 32'h6);
        bus(1'h1, OFS_CTRL, 32'h8);
        bus(1'h1, OFS_STATUS, 32'h0);
        repeat (400) @(posedge hclk);
        rchk(OFS_STATUS, 32'h976);
        rchk(OFS_SCALE, 32'hffffffff);
        chk({31'h0, pde}, 32'h1);
        $display("manual test done");
        pol <= 1'h1;
        bus(1'h1, OFS_CTRL, 32'h1);
        repeat (11000) @(posedge hclk);
        rchk(OFS_STATUS, 32'hf77);
        rchk(OFS_SCALE, 32'h08000800);
        $display("polarity test done");
        stop_test();
    end
endmodule
